// ==== bench/dac_host_model.sv ====
// host serial master model driving the converter's three-wire link
`timescale 1ns/1ps
module dac_host_model (
    output logic serialClk,
    output logic selectN,
    output logic dataOut
);
    ////////////////////////////////////////////////////////////////////////////
    // idle low clock
    initial begin
        serialClk = 1'b0;
        selectN   = 1'b1;
        dataOut   = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // msb first, optional mid-word pause
    task automatic send_word(input logic [15:0] w, input int nBits, input bit split);
        int i;
        logic [15:0] fw;
        // spare bit three high, four low
        fw = (w | 16'h2000) & ~16'h0400;
        #1.3;
        selectN = 1'b0;
        dataOut = fw[15];
        #50;
        for (i = 0; i < nBits; i++) begin
            // 48 ns period, data moves on falling edge
            serialClk = 1'b1;
            #24;
            serialClk = 1'b0;
            if (i + 1 < nBits) begin
                dataOut = fw[14-i];
            end
            #24;
            if (split && i == 7) begin
                #200; // clock parked, select held low
            end
        end
        #26;
        selectN = 1'b1;
        dataOut = ~dataOut; // released line shows no stale value
    endtask

    // stray clock edges with select high, to be ignored
    task automatic stray_clocks(input int n);
        int i;
        #1.3;
        for (i = 0; i < n; i++) begin
            dataOut = ~dataOut;
            #24;
            serialClk = 1'b1;
            #24;
            serialClk = 1'b0;
        end
    endtask
endmodule

// ==== bench/tb_dual_dac_serial_control.sv ====
// self-checking bench for the dual converter serial control block
`timescale 1ns/1ps
module tb_dual_dac_serial_control;
    import dac_ctrl_pkg::*;

    logic              core_clk;
    logic              reset_n;
    wire               serialClk;
    wire               selectN;
    wire               serialDataIn;
    logic [CODE_W-1:0] codeA;
    logic [CODE_W-1:0] codeB;
    logic              shutdownA;
    logic              shutdownB;
    logic [CODE_W-1:0] analogOutA;
    logic [CODE_W-1:0] analogOutB;
    logic [CTRL_W-1:0] lastControl;
    logic              commandDone;
    logic              frameIncomplete;
    logic [CODE_W-1:0] expA;
    logic [CODE_W-1:0] expB;
    logic [CTRL_W-1:0] expCtl;
    logic              expShA;
    logic              expShB;
    int                errCount;
    int                checksDone;
    logic [7:0]        codes [6] = '{8'h00, 8'h01, 8'h7f, 8'h80, 8'h81, 8'hff};
    logic [15:0]       words [8] = '{16'he155, 16'h22ff, 16'h2012, 16'h2a01,
                                     16'h3000, 16'h2333, 16'h3b34, 16'h2000};
    int                lens  [8] = '{16, 16, 16, 16, 16, 12, 16, 16};

    ////////////////////////////////////////////////////////////////////////////
    // design and host model
    dual_dac_serial_control u_dut (
        .core_clk        (core_clk),
        .reset_n         (reset_n),
        .serialClk       (serialClk),
        .selectN         (selectN),
        .serialDataIn    (serialDataIn),
        .codeA           (codeA),
        .codeB           (codeB),
        .shutdownA       (shutdownA),
        .shutdownB       (shutdownB),
        .analogOutA      (analogOutA),
        .analogOutB      (analogOutB),
        .lastControl     (lastControl),
        .commandDone     (commandDone),
        .frameIncomplete (frameIncomplete)
    );

    dac_host_model u_host (
        .serialClk (serialClk),
        .selectN   (selectN),
        .dataOut   (serialDataIn)
    );

    // core clock, 4 ns period
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // compare and report
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errCount++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // all visible state against expectations
    task automatic check_state();
        check(codeA, expA);
        check(codeB, expB);
        check(analogOutA, expShA ? 8'h00 : expA);
        check(analogOutB, expShB ? 8'h00 : expB);
        check({7'h00, shutdownA}, {7'h00, expShA});
        check({7'h00, shutdownB}, {7'h00, expShB});
        check(lastControl, expCtl);
    endtask

    // one frame, wait for its pulse, then check
    task automatic do_word(input logic [15:0] w, input int n, input bit split);
        int k;
        u_host.send_word(w, n, split);
        k = 0;
        while (commandDone !== 1'b1 && frameIncomplete !== 1'b1 && k < 12) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        check({7'h00, commandDone}, {7'h00, n >= 16});
        check({7'h00, frameIncomplete}, {7'h00, n < 16});
        if (n >= 16) begin
            if (w[LOAD_CONV_A_POS]) expA = w[7:0];
            if (w[LOAD_CONV_B_POS]) expB = w[7:0];
            expShA = w[SHUTDOWN_CONV_A_POS];
            expShB = w[SHUTDOWN_CONV_B_POS];
            expCtl = w[15:8];
        end
        check_state();
        repeat (16) @(posedge core_clk);
        #1;
    endtask

    // reset pulse and cleared expectations
    task automatic do_reset();
        reset_n = 1'b0;
        {expA, expB, expCtl, expShA, expShB} = '0;
        repeat (4) @(posedge core_clk);
        #1;
        check_state();
        reset_n = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        errCount   = 0;
        checksDone = 0;
        reset_n    = 1'b0;
        #1;
        do_reset();
        $display("test reset done");
        foreach (codes[i]) begin
            do_word({8'h23, codes[i]}, 16, 1'b0);
        end
        $display("test code table done");
        foreach (words[i]) begin
            do_word(words[i], lens[i], i == 0);
        end
        $display("test control bits done");
        u_host.stray_clocks(8);
        repeat (4) @(posedge core_clk);
        #1;
        check({7'h00, commandDone | frameIncomplete}, 8'h00);
        check_state();
        do_word(16'h2342, 16, 1'b0);
        $display("test stray clocks done");
        do_reset();
        do_word(16'h2380, 16, 1'b1);
        $display("test mid-run reset done");
        final_report();
    end

    // watchdog
    initial begin
        #300us;
        errCount++;
        final_report();
    end
endmodule

// ==== src/bit_sync_2ff.sv ====
// two flip-flop level synchroniser into the core clock
`timescale 1ns/1ps
module bit_sync_2ff #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic asyncIn,
    output logic      syncOut
);

    typedef struct packed {
        logic meta;
        logic stable;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    // first stage feeds only the second stage
    always_comb begin
        next_st.meta   = asyncIn;
        next_st.stable = st.meta;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '{meta: RESET_VAL, stable: RESET_VAL};
        end else begin
            st <= next_st;
        end
    end

    assign syncOut = st.stable;

endmodule

// ==== src/dac_ctrl_pkg.sv ====
// shared constants for the dual converter serial control block
package dac_ctrl_pkg;

    // word and field widths
    localparam int             CODE_W      = 8;
    localparam int             CTRL_W      = 8;
    localparam int             WORD_W      = 16;
    localparam int             COUNT_W     = 5;

    // bits in a full command word, as a counter value
    localparam logic [4:0]     WORD_BITS   = 5'h10;
    localparam logic [4:0]     COUNT_ONE   = 5'h01;
    localparam logic [4:0]     COUNT_ZERO  = 5'h00;

    // control byte positions inside the shifted word (bit 15 arrives first)
    localparam int             SPARE_CTRL_1_POS    = 15;
    localparam int             SPARE_CTRL_2_POS    = 14;
    localparam int             SPARE_CTRL_3_POS    = 13;
    localparam int             SHUTDOWN_CONV_B_POS = 12;
    localparam int             SHUTDOWN_CONV_A_POS = 11;
    localparam int             SPARE_CTRL_4_POS    = 10;
    localparam int             LOAD_CONV_B_POS     = 9;
    localparam int             LOAD_CONV_A_POS     = 8;

    // data byte and control byte limits
    localparam int             CODE_MSB    = 7;
    localparam int             CODE_LSB    = 0;
    localparam int             CTRL_MSB    = 15;
    localparam int             CTRL_LSB    = 8;

    // reset and zero scale values
    localparam logic [7:0]     ZERO_CODE   = 8'h00;
    localparam logic [7:0]     ZERO_CTRL   = 8'h00;
    localparam logic [15:0]    ZERO_WORD   = 16'h0000;

    // fastest serial clock the host may run, in MHz
    localparam int             SCLK_MAX_MHZ = 25;

endpackage

// ==== src/dual_dac_serial_control.sv ====
// command execution and output control of the dual 8-bit converter
`timescale 1ns/1ps

// How it works
// - shift only while select is low
// - sample data on rising serial clock
// - sixteen bits, msb first, data last
// - select rising edge executes full word
// - control byte then data byte layout
// - control bits act independently
// - load bits copy data byte
// - no load bits leaves registers alone
// - shutdown zeroes output, keeps register
// - leaving shutdown restores stored code
// - single buffered, load drives output
// - output equals code over 256
// - reset clears registers, outputs zero
module dual_dac_serial_control
    import dac_ctrl_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               reset_n,
    input  wire logic               serialClk,
    input  wire logic               selectN,
    input  wire logic               serialDataIn,
    output logic [CODE_W-1:0]       codeA,
    output logic [CODE_W-1:0]       codeB,
    output logic                    shutdownA,
    output logic                    shutdownB,
    output logic [CODE_W-1:0]       analogOutA,
    output logic [CODE_W-1:0]       analogOutB,
    output logic [CTRL_W-1:0]       lastControl,
    output logic                    commandDone,
    output logic                    frameIncomplete
);

    ////////////////////////////////////////////////////////////////////////////
    // types and state

    typedef struct packed {
        logic               selDly;
        logic [CODE_W-1:0]  regA;
        logic [CODE_W-1:0]  regB;
        logic               shutA;
        logic               shutB;
        logic [CODE_W-1:0]  analog_out_a;
        logic [CODE_W-1:0]  analog_out_b;
        logic [CTRL_W-1:0]  ctrl;
        logic               done;
        logic               shortFrame;
    } core_state_t;

    core_state_t            st;
    core_state_t            next_st;

    logic [WORD_W-1:0]      linkWord;
    logic [COUNT_W-1:0]     linkCount;
    logic                   selSync;
    logic                   selRise;
    logic                   wordComplete;
    logic [CODE_W-1:0]      dataByte;
    logic                   loadA;
    logic                   loadB;
    logic                   shutCmdA;
    logic                   shutCmdB;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // level presented by one converter: zero scale in shutdown, else its code
    function automatic logic [CODE_W-1:0] outputLevel(
        input logic              shut,
        input logic [CODE_W-1:0] code
    );
        logic [CODE_W-1:0] level;
        if (shut) begin
            level = ZERO_CODE;
        end else begin
            level = code;
        end
        return level;
    endfunction

    // one control bit of the shifted word; every bit is decoded alone
    function automatic logic ctrlBit(
        input logic [WORD_W-1:0] word,
        input int                pos
    );
        return word[pos];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // link side: shifter on the serial clock, select synchroniser on the core clock

    serial_word_shifter u_shifter (
        .serialClk  (serialClk),
        .reset_n    (reset_n),
        .selectN    (selectN),
        .dataIn     (serialDataIn),
        .shiftWord  (linkWord),
        .bitCount   (linkCount)
    );

    // select pin brought into the core clock; idles deselected
    bit_sync_2ff #(
        .RESET_VAL  (1'b1)
    ) u_sel_sync (
        .core_clk   (core_clk),
        .reset_n    (reset_n),
        .asyncIn    (selectN),
        .syncOut    (selSync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // word fields
    // the link word and count only change on serial clock edges while the
    // select is low, so they are settled by the time the synchronised
    // select rise is seen here; the select itself acts as the handshake
    // limitation: the host must hold the select high for at least three core
    // cycles between frames, or a new frame could start shifting while the
    // previous word is still being executed here

    assign selRise      = selSync & ~st.selDly;
    assign wordComplete = (linkCount == WORD_BITS);

    assign dataByte = linkWord[CODE_MSB:CODE_LSB];
    assign loadA    = ctrlBit(linkWord, LOAD_CONV_A_POS);
    assign loadB    = ctrlBit(linkWord, LOAD_CONV_B_POS);
    assign shutCmdA = ctrlBit(linkWord, SHUTDOWN_CONV_A_POS);
    assign shutCmdB = ctrlBit(linkWord, SHUTDOWN_CONV_B_POS);

    ////////////////////////////////////////////////////////////////////////////
    // command execution

    always_comb begin
        next_st            = st;
        next_st.selDly     = selSync;
        next_st.done       = 1'b0;
        next_st.shortFrame = 1'b0;
        if (selRise) begin
            if (wordComplete) begin
                next_st.done = 1'b1;
                next_st.ctrl = linkWord[CTRL_MSB:CTRL_LSB];
                if (loadA) begin
                    next_st.regA = dataByte;
                end
                if (loadB) begin
                    next_st.regB = dataByte;
                end
                next_st.shutA = shutCmdA;
                next_st.shutB = shutCmdB;
            end else begin
                // short frame: nothing executes
                next_st.shortFrame = 1'b1;
            end
        end
        next_st.analog_out_a = outputLevel(next_st.shutA, next_st.regA);
        next_st.analog_out_b = outputLevel(next_st.shutB, next_st.regB);
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '{selDly:     1'b1,
                    regA:       ZERO_CODE,
                    regB:       ZERO_CODE,
                    shutA:      1'b0,
                    shutB:      1'b0,
                    analog_out_a:       ZERO_CODE,
                    analog_out_b:       ZERO_CODE,
                    ctrl:       ZERO_CTRL,
                    done:       1'b0,
                    shortFrame: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flip-flops
    assign codeA           = st.regA;
    assign codeB           = st.regB;
    assign shutdownA       = st.shutA;
    assign shutdownB       = st.shutB;
    assign analogOutA      = st.analog_out_a;
    assign analogOutB      = st.analog_out_b;
    assign lastControl     = st.ctrl;
    assign commandDone     = st.done;
    assign frameIncomplete = st.shortFrame;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    // these watch what the host can see at the outputs; the link-side
    // properties sit with the shift register in its own clock domain

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    a_load_a_copy: assert property (
        selRise && wordComplete && loadA |=> codeA == $past(dataByte) && commandDone)
        else $error("converter A not loaded");

    a_load_b_copy: assert property (
        selRise && wordComplete && loadB |=> codeB == $past(dataByte) && commandDone)
        else $error("converter B not loaded");

    a_no_load_hold: assert property (
        selRise && !loadA && !loadB |=> $stable(codeA) && $stable(codeB))
        else $error("register changed without load");

    a_short_frame: assert property (
        selRise && !wordComplete |=>
            frameIncomplete && !commandDone && $stable(codeA) && $stable(codeB)
            && $stable(shutdownA) && $stable(shutdownB))
        else $error("incomplete word executed");

    a_quiet_between: assert property (
        !selRise |=> !commandDone && !frameIncomplete && $stable(codeA) && $stable(codeB)
            && $stable(shutdownA) && $stable(shutdownB))
        else $error("state moved without select rise");

    a_shut_exec: assert property (
        selRise && wordComplete |=>
            shutdownA == $past(shutCmdA) && shutdownB == $past(shutCmdB))
        else $error("shutdown bits not applied");

    a_shut_zero: assert property (
        shutdownA || shutdownB |->
            (!shutdownA || analogOutA == ZERO_CODE) && (!shutdownB || analogOutB == ZERO_CODE))
        else $error("output not zero in shutdown");

    a_restore_code: assert property (
        $fell(shutdownA) && $stable(codeA) |-> analogOutA == $past(codeA))
        else $error("converter A not restored");

    a_single_buffer: assert property (
        !shutdownB |-> analogOutB == codeB)
        else $error("converter B output not its register");

    // exec within three cycles of select rise
    a_exec_latency: assert property (
        $rose(selectN) ##1 selectN[*2] |-> ##[0:2] (commandDone || frameIncomplete))
        else $error("command not executed after select rise");

    a_restore_code_b: assert property (
        $fell(shutdownB) && $stable(codeB) |-> analogOutB == $past(codeB))
        else $error("converter B not restored");

    a_single_buffer_a: assert property (
        !shutdownA |-> analogOutA == codeA)
        else $error("converter A output not its register");

    a_load_both: assert property (
        selRise && wordComplete && loadA && loadB |=> codeA == codeB && codeA == $past(dataByte))
        else $error("both registers not loaded alike");

    a_load_a_only: assert property (
        selRise && wordComplete && loadA && !loadB |=> $stable(codeB))
        else $error("converter B moved on load A");

    a_load_b_only: assert property (
        selRise && wordComplete && loadB && !loadA |=> $stable(codeA))
        else $error("converter A moved on load B");

    a_shut_keep_a: assert property (
        selRise && wordComplete && shutCmdA && !loadA |=> $stable(codeA) && analogOutA == ZERO_CODE)
        else $error("converter A register lost in shutdown");

    a_shut_keep_b: assert property (
        selRise && wordComplete && shutCmdB && !loadB |=> $stable(codeB) && analogOutB == ZERO_CODE)
        else $error("converter B register lost in shutdown");

    a_ctrl_capture: assert property (
        selRise && wordComplete |=> lastControl == $past(linkWord[CTRL_MSB:CTRL_LSB]))
        else $error("control byte not captured");

    a_short_keep: assert property (
        selRise && !wordComplete |=>
            $stable(lastControl) && $stable(analogOutA) && $stable(analogOutB))
        else $error("short frame changed outputs");

    a_pulse_one: assert property (
        commandDone || frameIncomplete |=> !commandDone && !frameIncomplete)
        else $error("result pulse longer than one cycle");

    a_pulse_excl: assert property (
        !(commandDone && frameIncomplete))
        else $error("done and short frame together");

    a_no_load_done: assert property (
        selRise && wordComplete && !loadA && !loadB |=> commandDone && $stable(codeA) && $stable(codeB))
        else $error("word without load not executed cleanly");

    a_code_out_a: assert property (
        selRise && wordComplete && loadA && !shutCmdA |=> analogOutA == $past(dataByte))
        else $error("output A not at loaded code");

    a_code_out_b: assert property (
        selRise && wordComplete && loadB && !shutCmdB |=> analogOutB == $past(dataByte))
        else $error("output B not at loaded code");

    a_quiet_outputs: assert property (
        !selRise |=> $stable(analogOutA) && $stable(analogOutB) && $stable(lastControl))
        else $error("outputs moved without select rise");

    a_reset_clear: assert property (
        $rose(reset_n) |->
            codeA == ZERO_CODE && codeB == ZERO_CODE && !shutdownA && !shutdownB
            && analogOutA == ZERO_CODE && analogOutB == ZERO_CODE && lastControl == ZERO_CTRL)
        else $error("state not cleared by reset");

endmodule

// ==== src/serial_word_shifter.sv ====
// link-side shift register and bit counter, clocked by the serial clock
`timescale 1ns/1ps
module serial_word_shifter
    import dac_ctrl_pkg::*;
(
    input  wire logic               serialClk,
    input  wire logic               reset_n,
    input  wire logic               selectN,
    input  wire logic               dataIn,
    output logic [WORD_W-1:0]       shiftWord,
    output logic [COUNT_W-1:0]      bitCount
);

    typedef struct packed {
        logic [WORD_W-1:0]  word;
        logic [COUNT_W-1:0] count;
    } shift_state_t;

    shift_state_t st;
    shift_state_t next_st;
    logic         inFrame;
    logic         frameRstN;

    // frame flag is cleared whenever the select is released
    assign frameRstN = reset_n & ~selectN;

    always_ff @(posedge serialClk or negedge frameRstN) begin
        if (!frameRstN) begin
            inFrame <= 1'b0;
        end else begin
            inFrame <= 1'b1;
        end
    end

    // shift and count only while selected
    always_comb begin
        next_st = st;
        if (!selectN) begin
            next_st.word = {st.word[WORD_W-2:0], dataIn};
            if (!inFrame) begin
                next_st.count = COUNT_ONE;  // first edge of a new frame
            end else if (st.count != WORD_BITS) begin
                next_st.count = st.count + COUNT_ONE;
            end
        end
    end

    always_ff @(posedge serialClk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '{word: ZERO_WORD, count: COUNT_ZERO};
        end else begin
            st <= next_st;
        end
    end

    assign shiftWord = st.word;
    assign bitCount  = st.count;

    a_shift_sample: assert property (@(posedge serialClk) disable iff (!reset_n)
        !selectN |=> shiftWord[0] == $past(dataIn)) else $error("serial bit not sampled");
    a_hold_deselect: assert property (@(posedge serialClk) disable iff (!reset_n)
        selectN |=> $stable(shiftWord) && $stable(bitCount)) else $error("shift moved while deselected");

endmodule
